// ===== logic/irq_bank_pkg.sv
// Constants, offsets and field layouts of the interrupt request/enable bank.
package irq_bank_pkg;

	// Bus and register widths.
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int REG_W   = 8;
	localparam int N_CTL   = 4;
	localparam int N_GRP   = 5;
	localparam int N_SLOT  = 16;
	localparam int VEC_W   = 4;

	// Byte addresses of the registers on the bus.
	localparam logic [7:0] OFS_EDGE_CFG = 8'h00;
	localparam logic [7:0] OFS_CTL [N_CTL] = '{8'h04, 8'h08, 8'h0C, 8'h10};
	localparam logic [7:0] OFS_GRP [N_GRP] =
		'{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
	localparam logic [7:0] OFS_VEC_STAT = 8'h28;

	// Every control byte but the first keeps enables low and their flags four bits up.
	localparam int EN_LSB   = 0;
	localparam int FLAG_LSB = 4;
	localparam int PAIRS    = 4;

	// The first primary register is the exception: bit 0 is the global
	// enable and bit 7 is absent, so its flags sit one place below their
	// enables' partners and its sources take slots 1 to 3.
	localparam int CTL0_SKEW  = 1;
	localparam int SLOT_EXT_A = 1;
	localparam int SLOT_ERR   = 2;
	localparam int SLOT_PHASE = 3;

	// Fields of the primary control registers.
	localparam int GLOBAL_EN_BIT = 0;
	localparam int EXT_A_FLAG    = 4;
	localparam int ERR_FLAG      = 5;
	localparam int PHASE_FLAG    = 6;
	localparam int SERIAL_FLAG   = 7;
	localparam int OVP_FLAG_LSB  = 4;
	localparam int EXT_B_FLAG    = 6;
	localparam int GRP0_FLAG     = 7;

	// Edge configuration fields and the bits that really exist.
	localparam int EDGE_A_LSB = 0;
	localparam int EDGE_B_LSB = 2;
	localparam logic [7:0] EDGE_CFG_MASK = 8'h0F;
	localparam logic [7:0] CTL0_MASK     = 8'h7F;
	localparam logic [7:0] FULL_MASK     = 8'hFF;
	localparam logic [7:0] GRP4_MASK     = 8'h77;

	// Status word layout: pending bit and offered vector.
	localparam int STAT_REQ_BIT = 7;

	// Reset value of every register byte.
	localparam logic [7:0] REG_RST = 8'h00;

	// Trigger edge selection of an external pin.
	typedef enum logic [1:0] {
		ES_OFF  = 2'h0,
		ES_RISE = 2'h1,
		ES_FALL = 2'h2,
		ES_BOTH = 2'h3
	} edge_sel_e;

endpackage : irq_bank_pkg

// ===== logic/pin_edge_detect.sv
// Turns a synchronous pin level into a one-cycle pulse on the selected edge.
`timescale 1ns/10ps
module pin_edge_detect (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  pin,
	input  wire irq_bank_pkg::edge_sel_e sel,
	output logic                       hit_q
);
	import irq_bank_pkg::*;

	// All state of the detector.
	typedef struct packed {
		logic prev;  // Pin level one cycle earlier.
		logic hit;   // Registered edge pulse.
	} det_s;

	det_s s_q;  // Current state.
	det_s s_d;  // Next state.

	// Compare the pin with its last level and qualify by the edge select.
	always_comb begin
		s_d = s_q;
		s_d.prev = pin;
		case (sel)
			ES_RISE: s_d.hit = pin & ~s_q.prev;
			ES_FALL: s_d.hit = ~pin & s_q.prev;
			ES_BOTH: s_d.hit = pin ^ s_q.prev;
			default: s_d.hit = 1'b0;
		endcase
	end

	// The previous level resets low, so a pin high at release reads as a rise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hit_q = s_q.hit;

endmodule : pin_edge_detect

// ===== logic/grouped_req_reg.sv
// One grouped register: four secondary flags and enables and a group pulse.
`timescale 1ns/10ps
module grouped_req_reg #(
	parameter logic [7:0] IMPL_MASK = 8'hFF
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       wr_stb,
	input  wire logic [7:0] wdata,
	input  wire logic [3:0] evt,
	output logic      [7:0] reg_q,
	output logic            pend,
	output logic            set_q
);
	import irq_bank_pkg::*;

	// All state of one grouped register.
	typedef struct packed {
		logic [7:0] bits;  // Flags high, enables low.
		logic       prev;  // Group pending one cycle earlier.
		logic       set;   // Pulse towards the primary group flag.
	} grp_s;

	grp_s s_q;  // Current state.
	grp_s s_d;  // Next state.

	// Software writes first, then hardware events set flags so they win.
	always_comb begin
		s_d = s_q;
		if (wr_stb) begin
			s_d.bits = wdata & IMPL_MASK;
		end
		s_d.bits[FLAG_LSB +: PAIRS] = s_d.bits[FLAG_LSB +: PAIRS]
			| (evt & IMPL_MASK[FLAG_LSB +: PAIRS]);
		s_d.prev = pend;
		s_d.set  = pend & ~s_q.prev;
	end

	// Register the state; every bit clears at reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_q = s_q.bits;
	// A pending enabled secondary request drives the group flag.
	assign pend  = |(s_q.bits[FLAG_LSB +: PAIRS] & s_q.bits[EN_LSB +: PAIRS]);
	assign set_q = s_q.set;

endmodule : grouped_req_reg

// ===== logic/irq_req_bank.sv
// Interrupt request and enable register bank with an APB register port.
`timescale 1ns/10ps
module irq_req_bank (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_pin_a,
	input  wire logic        ext_pin_b,
	input  wire logic        phase_prot_evt,
	input  wire logic        error_signal_evt,
	input  wire logic        serial_if_evt,
	input  wire logic [4:0]  overvolt_evt,
	input  wire logic [19:0] grouped_evt,
	input  wire logic        stack_full,
	input  wire logic        int_ack,
	output logic             int_req,
	output logic      [3:0]  int_vec
);
	import irq_bank_pkg::*;

	// All state of the bank apart from the grouped registers and the pin edge detectors.
	typedef struct packed {
		logic [7:0]            edge_cfg;  // Edge selects of both pins.
		logic [N_CTL-1:0][7:0] ctl;       // Primary control registers.
		logic [31:0]           rdata;     // Read data for the access phase.
		logic                  ready;     // Access phase answer.
		logic                  slverr;    // Unmapped address answer.
		logic                  req;       // Interrupt offered to the core.
		logic [VEC_W-1:0]      vec;       // Vector of the offered source.
	} bank_s;

	bank_s s_q;  // Current state.
	bank_s s_d;  // Next state.

	logic [7:0]        grp_q [N_GRP];   // Grouped register contents.
	logic [N_GRP-1:0]  grp_pend;        // Group has an enabled request.
	logic [N_GRP-1:0]  grp_set;         // Group request newly pending.
	logic [N_GRP-1:0]  grp_wr;          // Write strobe per grouped register.
	logic              hit_a;           // First pin edge pulse.
	logic              hit_b;           // Second pin edge pulse.
	logic              bus_setup;       // Setup phase of a transfer.
	logic              bus_wr;          // Completing write transfer.
	logic [N_SLOT-1:0] slot_set;        // Hardware set per primary slot.

	// Enabled and flagged pairs of one control byte.
	function automatic logic [PAIRS-1:0] pairs_pending(input logic [7:0] r);
		pairs_pending = r[FLAG_LSB +: PAIRS] & r[EN_LSB +: PAIRS];
	endfunction : pairs_pending

	// Flag bit of a slot inside its control byte. The enable of slot v is
	// always bit v mod 4; only the first byte shifts its flags one down.
	// Getting this wrong would let one source's enable unmask another.
	function automatic int flag_pos(input logic [VEC_W-1:0] v);
		int b;
		b = FLAG_LSB + int'(v[1:0]);
		if (v < VEC_W'(PAIRS)) begin
			b = b - CTL0_SKEW;
		end
		flag_pos = b;
	endfunction : flag_pos

	// Pending slots of all primary registers; slot 0 is the global
	// enable itself and therefore never requests.
	function automatic logic [N_SLOT-1:0] slots_pending(
		input logic [N_CTL-1:0][7:0] c
	);
		logic [N_SLOT-1:0] p;
		p = '0;
		for (int r = 1; r < N_CTL; r++) begin
			p[r*PAIRS +: PAIRS] = pairs_pending(c[r]);
		end
		// First byte: flags 6 to 4 pair with enables 3 to 1.
		p[CTL0_SKEW +: PAIRS-1] = c[0][EXT_A_FLAG +: PAIRS-1]
			& c[0][EN_LSB + CTL0_SKEW +: PAIRS-1];
		p[0] = 1'b0;
		slots_pending = p;
	endfunction : slots_pending

	// Lowest numbered pending slot wins; this fixes the service priority.
	function automatic logic [VEC_W-1:0] pick(input logic [N_SLOT-1:0] p);
		logic [VEC_W-1:0] v;
		v = '0;
		for (int i = N_SLOT - 1; i >= 0; i--) begin
			if (p[i]) begin
				v = VEC_W'(i);
			end
		end
		pick = v;
	endfunction : pick

	// True when the address hits one of the implemented words.
	function automatic logic is_mapped(input logic [7:0] a);
		logic m;
		m = (a == OFS_EDGE_CFG) || (a == OFS_VEC_STAT);
		for (int r = 0; r < N_CTL; r++) begin
			m = m | (a == OFS_CTL[r]);
		end
		for (int g = 0; g < N_GRP; g++) begin
			m = m | (a == OFS_GRP[g]);
		end
		is_mapped = m;
	endfunction : is_mapped

	// Bus phases. The slave answers in the first access cycle.
	assign bus_setup = psel & ~penable;
	assign bus_wr    = psel & penable & s_q.ready & pwrite;

	// Edge detectors for both external pins.
	pin_edge_detect u_edge_a (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_pin_a),
		.sel     (edge_sel_e'(s_q.edge_cfg[EDGE_A_LSB +: 2])),
		.hit_q   (hit_a)
	);

	pin_edge_detect u_edge_b (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_pin_b),
		.sel     (edge_sel_e'(s_q.edge_cfg[EDGE_B_LSB +: 2])),
		.hit_q   (hit_b)
	);

	// Five grouped registers feed the group flags of the primary bank.
	for (genvar g = 0; g < N_GRP; g++) begin : g_grp
		assign grp_wr[g] = bus_wr & (paddr == OFS_GRP[g]);
		grouped_req_reg #(
			.IMPL_MASK ((g == N_GRP - 1) ? GRP4_MASK : FULL_MASK)
		) u_grp (
			.pclk    (pclk),
			.presetn (presetn),
			.wr_stb  (grp_wr[g]),
			.wdata   (pwdata[7:0]),
			.evt     (grouped_evt[g*PAIRS +: PAIRS]),
			.reg_q   (grp_q[g]),
			.pend    (grp_pend[g]),
			.set_q   (grp_set[g])
		);
	end

	// Map every hardware source onto its primary flag slot.
	always_comb begin
		slot_set = '0;
		slot_set[SLOT_EXT_A]                       = hit_a;
		slot_set[SLOT_ERR]                         = error_signal_evt;
		slot_set[SLOT_PHASE]                       = phase_prot_evt;
		slot_set[1*PAIRS +: 3]                     = overvolt_evt[2:0];
		slot_set[SERIAL_FLAG - FLAG_LSB + 1*PAIRS] = serial_if_evt;
		slot_set[2*PAIRS +: 2]                     = overvolt_evt[4:3];
		slot_set[EXT_B_FLAG - FLAG_LSB + 2*PAIRS]  = hit_b;
		slot_set[GRP0_FLAG - FLAG_LSB + 2*PAIRS]   = grp_set[0];
		slot_set[3*PAIRS +: PAIRS]                 = grp_set[N_GRP-1:1];
	end

	// Next state: bus answer, software writes, acknowledge, hardware sets.
	always_comb begin
		s_d = s_q;
		s_d.ready = bus_setup;
		if (bus_setup) begin
			// Read data is captured in the setup phase for a registered answer.
			s_d.rdata  = '0;
			s_d.slverr = ~is_mapped(paddr);
			if (paddr == OFS_EDGE_CFG) begin
				s_d.rdata[7:0] = s_q.edge_cfg;
			end
			if (paddr == OFS_VEC_STAT) begin
				s_d.rdata[STAT_REQ_BIT] = s_q.req;
				s_d.rdata[VEC_W-1:0]    = s_q.vec;
			end
			for (int r = 0; r < N_CTL; r++) begin
				if (paddr == OFS_CTL[r]) begin
					s_d.rdata[7:0] = s_q.ctl[r];
				end
			end
			for (int g = 0; g < N_GRP; g++) begin
				if (paddr == OFS_GRP[g]) begin
					s_d.rdata[7:0] = grp_q[g];
				end
			end
		end else begin
			// Outside the setup phase the answer returns to an idle zero.
			s_d.rdata  = '0;
			s_d.slverr = 1'b0;
		end
		// Software writes keep only the implemented bits.
		if (bus_wr && paddr == OFS_EDGE_CFG) begin
			s_d.edge_cfg = pwdata[7:0] & EDGE_CFG_MASK;
		end
		for (int r = 0; r < N_CTL; r++) begin
			if (bus_wr && paddr == OFS_CTL[r]) begin
				s_d.ctl[r] = pwdata[7:0] & ((r == 0) ? CTL0_MASK : FULL_MASK);
			end
		end
		// The core's acknowledge clears the flag of the offered vector.
		if (int_ack && s_q.req) begin
			s_d.ctl[s_q.vec[3:2]][flag_pos(s_q.vec)] = 1'b0;
		end
		// Hardware sets come last so an event is never lost to a clear.
		for (int i = 1; i < N_SLOT; i++) begin
			if (slot_set[i]) begin
				s_d.ctl[i / PAIRS][flag_pos(VEC_W'(i))] = 1'b1;
			end
		end
		// Offer an interrupt only when all qualifiers hold.
		s_d.req = s_d.ctl[0][GLOBAL_EN_BIT] & ~stack_full
			& (|slots_pending(s_d.ctl));
		s_d.vec = pick(slots_pending(s_d.ctl));
	end

	// Register the whole bank state; every bit clears at power-on reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state flip-flops.
	assign prdata  = s_q.rdata;
	assign pready  = s_q.ready;
	assign pslverr = s_q.slverr;
	assign int_req = s_q.req;
	assign int_vec = s_q.vec;

	// Unimplemented bits of the edge configuration and the first control byte never hold a one.
	property p_rsvd_zero;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_cfg[7:4] == 4'h0) && (s_q.ctl[0][7] == 1'b0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("Reserved bit set in bank.");

	// An offered interrupt had global enable and free stack.
	property p_req_qual;
		@(posedge pclk) disable iff (!presetn)
		int_req |-> s_q.ctl[0][GLOBAL_EN_BIT] && !$past(stack_full);
	endproperty
	a_req_qual: assert property (p_req_qual)
		else $error("Interrupt offered without qualifiers.");

	// The offered vector points to a flagged and enabled slot.
	property p_vec_valid;
		@(posedge pclk) disable iff (!presetn)
		int_req |-> s_q.ctl[int_vec[3:2]][flag_pos(int_vec)]
			&& s_q.ctl[int_vec[3:2]][EN_LSB + int'(int_vec[1:0])];
	endproperty
	a_vec_valid: assert property (p_vec_valid)
		else $error("Vector points at an idle source.");

	// A phase protection event sets its flag at the next edge.
	property p_phase_set;
		@(posedge pclk) disable iff (!presetn)
		phase_prot_evt |=> s_q.ctl[0][PHASE_FLAG];
	endproperty
	a_phase_set: assert property (p_phase_set)
		else $error("Phase protection flag not set.");

	// A serial interface event sets its flag at the next edge.
	property p_serial_set;
		@(posedge pclk) disable iff (!presetn)
		serial_if_evt |=> s_q.ctl[1][SERIAL_FLAG];
	endproperty
	a_serial_set: assert property (p_serial_set)
		else $error("Serial interface flag not set.");

	// Overvoltage channel 2 lands in bit 6 of the second register.
	property p_ovp_set;
		@(posedge pclk) disable iff (!presetn)
		overvolt_evt[2] |=> s_q.ctl[1][OVP_FLAG_LSB + 2];
	endproperty
	a_ovp_set: assert property (p_ovp_set)
		else $error("Overvoltage flag not set.");

	// A rise of the first pin under rising select sets its flag two edges on.
	property p_ext_a_rise;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_cfg[EDGE_A_LSB +: 2] == ES_RISE) && $rose(ext_pin_a)
			|-> ##2 s_q.ctl[0][EXT_A_FLAG];
	endproperty
	a_ext_a_rise: assert property (p_ext_a_rise)
		else $error("First pin rise did not set its flag.");

	// Under both-edge select any change of the second pin sets its flag.
	property p_ext_b_both;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_cfg[EDGE_B_LSB +: 2] == ES_BOTH) && $changed(ext_pin_b)
			|-> ##2 s_q.ctl[2][EXT_B_FLAG];
	endproperty
	a_ext_b_both: assert property (p_ext_b_both)
		else $error("Second pin edge did not set its flag.");

	// A newly pending group request sets the first group flag.
	property p_grp_set;
		@(posedge pclk) disable iff (!presetn)
		$rose(grp_pend[0]) |-> ##2 s_q.ctl[2][GRP0_FLAG];
	endproperty
	a_grp_set: assert property (p_grp_set)
		else $error("Group flag not set by secondary request.");

	// An error signal event sets its flag at the next edge.
	property p_err_set;
		@(posedge pclk) disable iff (!presetn)
		error_signal_evt |=> s_q.ctl[0][ERR_FLAG];
	endproperty
	a_err_set: assert property (p_err_set)
		else $error("Error signal flag not set.");

	// A fall of the first pin under falling select sets its flag.
	property p_ext_a_fall;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_cfg[EDGE_A_LSB +: 2] == ES_FALL) && $fell(ext_pin_a)
			|-> ##2 s_q.ctl[0][EXT_A_FLAG];
	endproperty
	a_ext_a_fall: assert property (p_ext_a_fall)
		else $error("First pin fall did not set its flag.");

	// A fall of the second pin under falling select sets its flag.
	property p_ext_b_fall;
		@(posedge pclk) disable iff (!presetn)
		(s_q.edge_cfg[EDGE_B_LSB +: 2] == ES_FALL) && $fell(ext_pin_b)
			|-> ##2 s_q.ctl[2][EXT_B_FLAG];
	endproperty
	a_ext_b_fall: assert property (p_ext_b_fall)
		else $error("Second pin fall did not set its flag.");

endmodule : irq_req_bank

// ===== tb/core_ack_model.sv
// Behavioural core that acknowledges offered interrupts after a delay.
`timescale 1ns/10ps
module core_ack_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       int_req,
	input  wire logic [3:0] int_vec,
	input  wire logic       ack_on,
	input  wire logic [1:0] ack_dly,
	output logic            int_ack,
	output logic            taken_q,
	output logic      [3:0] taken_vec_q
);
	logic [1:0] wait_q; // Cycles the current offer has waited.

	// A slow core waits ack_dly cycles; the taken vector is the one seen
	// with the acknowledge, since the offer may change while waiting.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_ack     <= 1'b0;
			wait_q      <= 2'h0;
			taken_q     <= 1'b0;
			taken_vec_q <= 4'h0;
		end else begin
			taken_q     <= int_ack && int_req;
			taken_vec_q <= int_vec;
			if (int_ack) begin
				// One acknowledge per offer, never held.
				int_ack <= 1'b0;
				wait_q  <= 2'h0;
			end else if (int_req && ack_on) begin
				if (wait_q >= ack_dly) int_ack <= 1'b1;
				else wait_q <= wait_q + 2'h1;
			end else begin
				wait_q <= 2'h0;
			end
		end
	end
endmodule : core_ack_model

// ===== tb/irq_req_bank_tb_top.sv
// Self-checking bench for the interrupt request and enable bank.
`timescale 1ns/10ps
module irq_req_bank_tb_top;
	import irq_bank_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin_a;
	logic        pin_b;
	logic        phase_evt;
	logic        error_evt;
	logic        serial_evt;
	logic [4:0]  ovp_evt;
	logic [19:0] grp_evt;
	logic        stack_full;
	logic        int_ack;
	logic        int_req;
	logic [3:0]  int_vec;
	logic        ack_on;
	logic [1:0]  ack_dly;
	logic        taken_q;
	logic [3:0]  taken_vec_q;
	logic [32:0] mon_e;        // Oldest bus note: error bit over data.
	logic [32:0] apb_q [$];    // Expected bus results in issue order.
	logic [3:0]  vec_q [$];    // Expected taken vectors in order.
	int          n_mismatch;
	int          comparisons;

	irq_req_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_pin_a(pin_a), .ext_pin_b(pin_b),
		.phase_prot_evt(phase_evt), .error_signal_evt(error_evt),
		.serial_if_evt(serial_evt), .overvolt_evt(ovp_evt),
		.grouped_evt(grp_evt), .stack_full(stack_full),
		.int_ack(int_ack), .int_req(int_req), .int_vec(int_vec));
	core_ack_model core (.pclk(pclk), .presetn(presetn),
		.int_req(int_req), .int_vec(int_vec), .ack_on(ack_on),
		.ack_dly(ack_dly), .int_ack(int_ack), .taken_q(taken_q),
		.taken_vec_q(taken_vec_q));

	// Free running 20 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Hang guard, well beyond the few hundred cycles the tests need.
	initial begin
		#(50 * 30000);
		n_mismatch++;
		tally_and_finish();
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Checks each bus answer and each taken vector against the notes.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			mon_e = apb_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, mon_e[32]});
			if (!pwrite) chk(prdata, mon_e[31:0]);
		end
		if (taken_q === 1'b1) begin
			chk({28'h0, taken_vec_q}, {28'h0, vec_q.pop_front()});
		end
	end

	// One APB transfer; the request stands until pready is seen high.
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		apb_q.push_back(e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) n_mismatch++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d}, 33'h0);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] x);
		xfer(1'b0, a, 32'h0, {25'h0, x});
	endtask : rd

	// Lets events land, then waits until every offer was taken.
	task wait_idle();
		int n;
		repeat (4) @(posedge pclk);
		n = 0;
		while ((vec_q.size() != 0 || int_req !== 1'b0) && n < 60) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 60) chk(32'(vec_q.size()), 32'h0);
	endtask : wait_idle

	// One cycle event of the primary source with vector slot s.
	task fire(input int s);
		@(posedge pclk);
		case (s)
			2: error_evt <= 1'b1;
			3: phase_evt <= 1'b1;
			7: serial_evt <= 1'b1;
			8, 9: ovp_evt[s-5] <= 1'b1;
			default: ovp_evt[s-4] <= 1'b1;
		endcase
		@(posedge pclk);
		error_evt  <= 1'b0;
		phase_evt  <= 1'b0;
		serial_evt <= 1'b0;
		ovp_evt    <= 5'h00;
	endtask : fire

	task tally_and_finish();
		chk(32'(vec_q.size()), 32'h0);
		$display("TB: mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// Main sequence.
	initial begin
		int r;
		int k;
		int m;
		int g;
		int slots [8];
		slots = '{2, 3, 4, 5, 6, 7, 8, 9};
		{psel, penable, pwrite, pin_a, pin_b, stack_full} = 6'h00;
		{phase_evt, error_evt, serial_evt, ack_on} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ovp_evt = 5'h00;
		grp_evt = 20'h00000;
		ack_dly = 2'h0;
		n_mismatch = 0;
		comparisons = 0;
		presetn = 1'b0;
		void'($urandom(32'hc029a02a));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_EDGE_CFG, REG_RST);
		for (r = 0; r < N_CTL; r++) rd(OFS_CTL[r], REG_RST);
		for (r = 0; r < N_GRP; r++) rd(OFS_GRP[r], REG_RST);
		xfer(1'b0, 8'h2C, 32'h0, {1'b1, 32'h0});
		xfer(1'b1, 8'h2C, 32'hFF, {1'b1, 32'h0});
		$display("TB: test reset_and_map done");
		// All ones shows which bits exist; the core stays idle meanwhile.
		wr(OFS_EDGE_CFG, 8'hFF);
		for (r = 0; r < N_CTL; r++) wr(OFS_CTL[r], 8'hFF);
		for (r = 0; r < N_GRP; r++) wr(OFS_GRP[r], 8'hFF);
		rd(OFS_EDGE_CFG, EDGE_CFG_MASK);
		rd(OFS_CTL[0], CTL0_MASK);
		for (r = 1; r < N_CTL; r++) rd(OFS_CTL[r], FULL_MASK);
		for (r = 0; r < 4; r++) rd(OFS_GRP[r], FULL_MASK);
		rd(OFS_GRP[4], GRP4_MASK);
		for (r = 0; r < N_GRP; r++) wr(OFS_GRP[r], 8'h00);
		wr(OFS_EDGE_CFG, 8'h00);
		for (r = 0; r < N_CTL; r++) wr(OFS_CTL[r], 8'h00);
		$display("TB: test masks done");
		ack_on <= 1'b1;
		wr(OFS_CTL[0], 8'h01);
		foreach (slots[i]) begin
			r = slots[i] / 4;
			k = slots[i] % 4;
			ack_dly <= 2'($urandom_range(3, 0));
			wr(OFS_CTL[r], 8'((1 << k) | (r == 0)));
			vec_q.push_back(4'(slots[i]));
			fire(slots[i]);
			wait_idle();
			rd(OFS_CTL[r], 8'((1 << k) | (r == 0)));
			wr(OFS_CTL[r], 8'(r == 0));
		end
		$display("TB: test primary_sources done");
		// Masked by the global enable, then by a full return stack.
		wr(OFS_CTL[0], 8'h08);
		fire(3);
		repeat (4) @(posedge pclk);
		chk({31'h0, int_req}, 32'h0);
		rd(OFS_CTL[0], 8'h48);
		stack_full <= 1'b1;
		ack_on <= 1'b0;
		wr(OFS_CTL[0], 8'h49);
		repeat (4) @(posedge pclk);
		chk({31'h0, int_req}, 32'h0);
		stack_full <= 1'b0;
		repeat (3) @(posedge pclk);
		rd(OFS_VEC_STAT, 8'h83);
		vec_q.push_back(4'd3);
		ack_on <= 1'b1;
		wait_idle();
		$display("TB: test masking done");
		// Pin b always runs the complement mode of pin a.
		wr(OFS_CTL[0], 8'h03);
		wr(OFS_CTL[2], 8'h04);
		for (m = 0; m < 4; m++) begin
			wr(OFS_EDGE_CFG, 8'(m | ((3 - m) << 2)));
			if (m & 1) vec_q.push_back(4'd1);
			if ((3 - m) & 1) vec_q.push_back(4'd10);
			pin_a <= 1'b1;
			pin_b <= 1'b1;
			wait_idle();
			if (m & 2) vec_q.push_back(4'd1);
			if ((3 - m) & 2) vec_q.push_back(4'd10);
			pin_a <= 1'b0;
			pin_b <= 1'b0;
			wait_idle();
		end
		rd(OFS_CTL[0], 8'h03);
		wr(OFS_EDGE_CFG, 8'h00);
		wr(OFS_CTL[0], 8'h01);
		wr(OFS_CTL[2], 8'h00);
		$display("TB: test pin_edges done");
		for (g = 0; g < N_GRP; g++) begin
			k = $urandom_range((g == 4) ? 2 : 3, 0);
			r = (g == 0) ? 2 : 3;
			wr(OFS_GRP[g], 8'(1 << k));
			wr(OFS_CTL[r], 8'(1 << ((g == 0) ? 3 : g - 1)));
			vec_q.push_back(4'(11 + g));
			@(posedge pclk);
			grp_evt <= 20'(1) << (4 * g + k);
			@(posedge pclk);
			grp_evt <= 20'h00000;
			wait_idle();
			rd(OFS_GRP[g], 8'(8'h11 << k));
			wr(OFS_GRP[g], 8'h00);
			wr(OFS_CTL[r], 8'h00);
		end
		$display("TB: test groups done");
		tally_and_finish();
	end
endmodule : irq_req_bank_tb_top
